// ===== rtl/clk_mode_regs.vh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and a word-aligned avalon-mm slave
`ifndef CLK_MODE_REGS_VH
`define CLK_MODE_REGS_VH

// register byte addresses (word aligned)
`define ADDR_SYS_CLK_CTRL 4'h0
`define ADDR_FAST_OSC_CTRL 4'h4
`define ADDR_CRYSTAL_CTRL 4'h8
`define ADDR_HALT_CTRL 4'hc

// system_clock_control fields
`define SCC_SEL_HI 7
`define SCC_SEL_LO 5
`define SCC_LFSS 2
`define SCC_FHK 1
`define SCC_SHK 0
`define SCC_RESET 8'he0

// fast_osc_control fields
`define FOC_FREQ_HI 3
`define FOC_FREQ_LO 2
`define FOC_STABLE 1
`define FOC_EN 0
`define FOC_RESET 8'h00

// crystal_osc_control fields
`define XOC_SPEEDUP 2
`define XOC_STABLE 1
`define XOC_EN 0
`define XOC_RESET 8'h00

// clock select codes
`define SEL_SUB 3'h7
`define SEL_DIV_MAX 3'h6

// fast oscillator frequency codes
`define FREQ_2MHZ 2'h0
`define FREQ_4MHZ 2'h1
`define FREQ_8MHZ 2'h2

// halt power modes
`define PM_RUN 3'h0
`define PM_SLEEP 3'h1
`define PM_IDLE_SLOW_ONLY 3'h2
`define PM_IDLE_BOTH_OSC 3'h3
`define PM_IDLE_FAST_ONLY 3'h4

// switch delay: whole i_clk_sys periods before the swap
`define SWITCH_SYS_PERIODS 4

`endif

// ===== rtl/glitch_free_clk_mux.v
// glitch-free two-input clock multiplexer with handshaking enables
// assumes both clocks are free-running while a switch is in progress
`timescale 1ns/1ns
module glitch_free_clk_mux (
	input wire i_clk_a,
	input wire i_clk_b,
	input wire i_rst,
	input wire i_sel_b,
	output wire o_clk,
	output wire o_on_b
);

////////////////////////////////////////////////////////////////////////
// each side enables only after the other has dropped, on falling edges
reg a_s1_r;
reg a_en_r;
reg b_s1_r;
reg b_en_r;

// side a: two stages, last on a falling edge to avoid runts
always @(posedge i_clk_a) begin
	if (i_rst) begin
		a_s1_r <= 1'b1;
	end else begin
		a_s1_r <= ~i_sel_b & ~b_en_r;
	end
end

always @(negedge i_clk_a) begin
	if (i_rst) begin
		a_en_r <= 1'b1;
	end else begin
		a_en_r <= a_s1_r;
	end
end

// side b mirrors side a
always @(posedge i_clk_b) begin
	if (i_rst) begin
		b_s1_r <= 1'b0;
	end else begin
		b_s1_r <= i_sel_b & ~a_en_r;
	end
end

always @(negedge i_clk_b) begin
	if (i_rst) begin
		b_en_r <= 1'b0;
	end else begin
		b_en_r <= b_s1_r;
	end
end

// gated or, each enable only changes while its clock is low
assign o_clk = (i_clk_a & a_en_r) | (i_clk_b & b_en_r);
assign o_on_b = b_en_r;

endmodule

// ===== rtl/system_clock_mode_control.v
// system clock and oscillator mode control with avalon-mm registers
// assumes oscillator clocks and ready levels arrive from analog blocks,
// each asynchronous to i_clk_sys; halt request is a pulse from the cpu
`timescale 1ns/1ns
`include "clk_mode_regs.vh"

// What this block does
// - select 000..110 gives fast clock divided 1..64, 111 gives sub clock
// - low freq select bit routes slow internal (0) or crystal (1) to sub
// - fast oscillator keeps running in halt only if its keep bit is 1
// - slow oscillator keeps running in halt only if its keep bit is 1
// - unimplemented bits of all three registers read as zero
// - clock switch completes in four i_clk_sys periods plus resync time
// - freq code 00 and 11 give 2MHz, 01 gives 4MHz, 10 gives 8MHz
// - new fast oscillator frequency applies only once stable flag sets
// - enabling fast oscillator clears its stable flag, sets when stable
// - fast oscillator enable bit turns the oscillator off or on
// - crystal speed-up bit picks fast-start or low-power crystal mode
// - speed-up writes ignored while crystal is the system clock
// - enabling crystal clears its stable flag, sets when stable
// - crystal enable turns the crystal on and feeds the time base
// - select field changes fast/slow; halt picks idle or sleep
// - switch to 111 completes only once low freq source is stable
// - halt mode: 00 sleep, slow-only idle_slow_only, both idle_both_osc, fast-only idle_fast_only
module system_clock_mode_control (
	input wire i_clk_sys,
	input wire i_rst,
	input wire [3:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output reg [31:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	input wire i_fast_osc_clk,
	input wire i_slow_osc_clk,
	input wire i_crystal_clk,
	input wire i_fast_osc_ready,
	input wire i_crystal_ready,
	input wire i_slow_osc_ready,
	input wire i_halt,
	input wire i_wake,
	output reg o_fast_osc_enable,
	output reg [1:0] o_fast_osc_freq_select,
	output reg o_crystal_enable,
	output reg o_crystal_speedup,
	output reg o_slow_osc_enable,
	output reg o_time_base_clk_en,
	output reg o_cpu_clk_en,
	output reg [2:0] o_power_mode,
	output reg o_switch_busy,
	output wire o_sys_clk
);

////////////////////////////////////////////////////////////////////////
// register state
reg [2:0] sys_clk_select_r;
reg low_freq_source_select_r;
reg fast_osc_halt_keep_r;
reg slow_osc_halt_keep_r;
reg [1:0] fast_osc_freq_select_r;
reg fast_osc_enable_r;
reg fast_osc_stable_flag_r;
reg crystal_speedup_r;
reg crystal_enable_r;
reg crystal_stable_flag_r;
reg [2:0] power_mode_r;
localparam [7:0] SCC_RST_VAL = `SCC_RESET;

// synchronisers for analog ready levels
reg [2:0] rdy_s1_r;
reg [2:0] rdy_s2_r;

always @(posedge i_clk_sys) begin
	if (i_rst) begin
		rdy_s1_r <= 3'h0;
		rdy_s2_r <= 3'h0;
	end else begin
		rdy_s1_r <= {i_slow_osc_ready, i_crystal_ready, i_fast_osc_ready};
		rdy_s2_r <= rdy_s1_r;
	end
end

wire fast_rdy = rdy_s2_r[0];
wire xtal_rdy = rdy_s2_r[1];
wire slow_rdy = rdy_s2_r[2];

////////////////////////////////////////////////////////////////////////
// avalon slave: one wait cycle on every access, read data registered
// writes land in the answer cycle, the edge that sees waitrequest low
reg ack_r;
wire req = (i_avs_read | i_avs_write) & ~ack_r;
wire wr = i_avs_write & ack_r & i_avs_byteenable[0];
wire wr_scc = wr & (i_avs_address == `ADDR_SYS_CLK_CTRL);
wire wr_foc = wr & (i_avs_address == `ADDR_FAST_OSC_CTRL);
wire wr_xoc = wr & (i_avs_address == `ADDR_CRYSTAL_CTRL);
wire [7:0] wd = i_avs_writedata[7:0];
wire xtal_is_sys = (sys_clk_select_r == `SEL_SUB) & low_freq_source_select_r;

reg [7:0] rd_byte;

// read mux, unimplemented and unmapped bits read zero
always @* begin
	case (i_avs_address)
	`ADDR_SYS_CLK_CTRL: rd_byte = {sys_clk_select_r, 2'b00,
		low_freq_source_select_r, fast_osc_halt_keep_r,
		slow_osc_halt_keep_r};
	`ADDR_FAST_OSC_CTRL: rd_byte = {4'h0, fast_osc_freq_select_r,
		fast_osc_stable_flag_r, fast_osc_enable_r};
	`ADDR_CRYSTAL_CTRL: rd_byte = {5'h00, crystal_speedup_r,
		crystal_stable_flag_r, crystal_enable_r};
	`ADDR_HALT_CTRL: rd_byte = {5'h00, power_mode_r};
	default: rd_byte = 8'h00;
	endcase
end

always @(posedge i_clk_sys) begin
	if (i_rst) begin
		ack_r <= 1'b0;
		o_avs_waitrequest <= 1'b1;
		o_avs_readdata <= 32'h0;
	end else begin
		ack_r <= req;
		o_avs_waitrequest <= ~req;
		if (req) begin
			o_avs_readdata <= {24'h000000, rd_byte};
		end
	end
end

////////////////////////////////////////////////////////////////////////
// control registers and stable flags
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		sys_clk_select_r <= SCC_RST_VAL[`SCC_SEL_HI:`SCC_SEL_LO];
		low_freq_source_select_r <= 1'b0;
		fast_osc_halt_keep_r <= 1'b0;
		slow_osc_halt_keep_r <= 1'b0;
		fast_osc_freq_select_r <= `FREQ_2MHZ;
		fast_osc_enable_r <= 1'b0;
		fast_osc_stable_flag_r <= 1'b0;
		crystal_speedup_r <= 1'b0;
		crystal_enable_r <= 1'b0;
		crystal_stable_flag_r <= 1'b0;
	end else begin
		if (wr_scc) begin
			sys_clk_select_r <= wd[`SCC_SEL_HI:`SCC_SEL_LO];
			low_freq_source_select_r <= wd[`SCC_LFSS];
			fast_osc_halt_keep_r <= wd[`SCC_FHK];
			slow_osc_halt_keep_r <= wd[`SCC_SHK];
		end
		if (wr_foc) begin
			fast_osc_freq_select_r <= wd[`FOC_FREQ_HI:`FOC_FREQ_LO];
			fast_osc_enable_r <= wd[`FOC_EN];
		end
		if (wr_xoc) begin
			crystal_enable_r <= wd[`XOC_EN];
			if (!xtal_is_sys) begin
				crystal_speedup_r <= wd[`XOC_SPEEDUP];
			end
		end
		// enable or retune restarts stabilisation; clear first
		if (wr_foc & wd[`FOC_EN] & (~fast_osc_enable_r |
			(wd[`FOC_FREQ_HI:`FOC_FREQ_LO] != fast_osc_freq_select_r))) begin
			fast_osc_stable_flag_r <= 1'b0;
		end else begin
			fast_osc_stable_flag_r <= fast_osc_enable_r & fast_rdy;
		end
		if (wr_xoc & wd[`XOC_EN] & ~crystal_enable_r) begin
			crystal_stable_flag_r <= 1'b0;
		end else begin
			crystal_stable_flag_r <= crystal_enable_r & xtal_rdy;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// halt mode decision from the two keep bits
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		power_mode_r <= `PM_RUN;
	end else if (i_wake) begin
		power_mode_r <= `PM_RUN;
	end else if (i_halt & (power_mode_r == `PM_RUN)) begin
		case ({fast_osc_halt_keep_r, slow_osc_halt_keep_r})
		2'b00: power_mode_r <= `PM_SLEEP;
		2'b01: power_mode_r <= `PM_IDLE_SLOW_ONLY;
		2'b11: power_mode_r <= `PM_IDLE_BOTH_OSC;
		default: power_mode_r <= `PM_IDLE_FAST_ONLY;
		endcase
	end
end

wire halted = (power_mode_r != `PM_RUN);

////////////////////////////////////////////////////////////////////////
// clock path: divider, sub source mux, fast/sub mux
reg [5:0] div_cnt_r;
reg [2:0] div_sel_r;
reg div_clk_r;
reg sel_sub_r;
reg lfss_r;
wire sub_clk;
wire sub_on_xtal;
wire sys_on_sub;

// applied divide ratio follows the select field
always @(posedge i_fast_osc_clk) begin
	if (i_rst) begin
		div_cnt_r <= 6'h00;
		div_clk_r <= 1'b0;
	end else begin
		div_cnt_r <= div_cnt_r + 6'h01;
		case (div_sel_r)
		3'h0: div_clk_r <= 1'b0;
		3'h1: div_clk_r <= div_cnt_r[0];
		3'h2: div_clk_r <= div_cnt_r[1];
		3'h3: div_clk_r <= div_cnt_r[2];
		3'h4: div_clk_r <= div_cnt_r[3];
		3'h5: div_clk_r <= div_cnt_r[4];
		default: div_clk_r <= div_cnt_r[5];
		endcase
	end
end

// divide-by-one passes the raw oscillator
wire fast_div_clk = (div_sel_r == 3'h0) ? i_fast_osc_clk : div_clk_r;

glitch_free_clk_mux sub_mux (
	.i_clk_a(i_slow_osc_clk),
	.i_clk_b(i_crystal_clk),
	.i_rst(i_rst),
	.i_sel_b(lfss_r),
	.o_clk(sub_clk),
	.o_on_b(sub_on_xtal)
);

glitch_free_clk_mux sys_mux (
	.i_clk_a(fast_div_clk),
	.i_clk_b(sub_clk),
	.i_rst(i_rst),
	.i_sel_b(sel_sub_r),
	.o_clk(o_sys_clk),
	.o_on_b(sys_on_sub)
);

////////////////////////////////////////////////////////////////////////
// switch sequencer: wait settle periods and target stability
localparam SW_IDLE = 2'h0;
localparam SW_WAIT = 2'h1;
localparam SW_APPLY = 2'h2;

reg [1:0] sw_state_r;
reg [2:0] sw_cnt_r;
wire lf_ready = low_freq_source_select_r ? crystal_stable_flag_r : slow_rdy;
wire tgt_sub = (sys_clk_select_r == `SEL_SUB);
wire changed = (tgt_sub != sel_sub_r) | (low_freq_source_select_r != lfss_r)
	| (~tgt_sub & (sys_clk_select_r != div_sel_r));

always @(posedge i_clk_sys) begin
	if (i_rst) begin
		sw_state_r <= SW_IDLE;
		sw_cnt_r <= 3'h0;
		sel_sub_r <= 1'b1;
		lfss_r <= 1'b0;
		div_sel_r <= `SEL_DIV_MAX;
	end else begin
		case (sw_state_r)
		SW_IDLE: begin
			sw_cnt_r <= 3'h0;
			if (changed) begin
				sw_state_r <= SW_WAIT;
			end
		end
		SW_WAIT: begin
			if (sw_cnt_r != `SWITCH_SYS_PERIODS - 1) begin
				sw_cnt_r <= sw_cnt_r + 3'h1;
			end else if (tgt_sub ? lf_ready : fast_osc_stable_flag_r) begin
				sw_state_r <= SW_APPLY;
			end
		end
		SW_APPLY: begin
			sel_sub_r <= tgt_sub;
			lfss_r <= low_freq_source_select_r;
			if (!tgt_sub) begin
				div_sel_r <= sys_clk_select_r;
			end
			sw_state_r <= SW_IDLE;
		end
		default: sw_state_r <= SW_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// oscillator enables and status outputs
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		o_fast_osc_enable <= 1'b0;
		o_fast_osc_freq_select <= `FREQ_2MHZ;
		o_crystal_enable <= 1'b0;
		o_crystal_speedup <= 1'b0;
		o_slow_osc_enable <= 1'b1;
		o_time_base_clk_en <= 1'b0;
		o_cpu_clk_en <= 1'b1;
		o_power_mode <= `PM_RUN;
		o_switch_busy <= 1'b0;
	end else begin
		// halted: fast stays only with its keep bit
		o_fast_osc_enable <= fast_osc_enable_r & (~halted |
			fast_osc_halt_keep_r);
		// code 11 maps back to 2MHz; hold old code until stable
		if (fast_osc_stable_flag_r) begin
			o_fast_osc_freq_select <= (fast_osc_freq_select_r == 2'h3) ?
				`FREQ_2MHZ : fast_osc_freq_select_r;
		end
		o_crystal_enable <= crystal_enable_r &
			(~halted | slow_osc_halt_keep_r);
		o_crystal_speedup <= crystal_speedup_r;
		o_slow_osc_enable <= ~halted | slow_osc_halt_keep_r;
		o_time_base_clk_en <= crystal_stable_flag_r;
		o_cpu_clk_en <= ~halted;
		o_power_mode <= power_mode_r;
		o_switch_busy <= (sw_state_r != SW_IDLE) | changed;
	end
end

endmodule

// ===== verification/system_clock_mode_control_checker.sv
// concurrent checks on the clock mode control ports
// assumes one clock domain and a bind onto the top module
`timescale 1ns/1ns
`include "clk_mode_regs.vh"
module system_clock_mode_control_checker (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_fast_osc_ready,
	input wire logic i_crystal_ready,
	input wire logic i_halt,
	input wire logic i_wake,
	input wire logic o_fast_osc_enable,
	input wire logic [1:0] o_fast_osc_freq_select,
	input wire logic o_crystal_enable,
	input wire logic o_slow_osc_enable,
	input wire logic o_time_base_clk_en,
	input wire logic o_cpu_clk_en,
	input wire logic [2:0] o_power_mode,
	input wire logic o_switch_busy
);
////////////////////////////////////////////////////////////////////////////
// one clock, reset disables all
default clocking cb @(posedge i_clk_sys);
endclocking
default disable iff (i_rst);
////////////////////////////////////////////////////////////////////////////
chk_read_unused_zero: assert property (
	!o_avs_waitrequest && i_avs_read |-> o_avs_readdata[31:8] == 24'h0
	&& (i_avs_address != `ADDR_SYS_CLK_CTRL || o_avs_readdata[4:3] == 2'h0)
	&& (i_avs_address != `ADDR_FAST_OSC_CTRL || o_avs_readdata[7:4] == 4'h0)
	&& (i_avs_address != `ADDR_CRYSTAL_CTRL || o_avs_readdata[7:3] == 5'h0)
) else $error("unused bits read nonzero");
chk_halt_leaves_run: assert property (
	i_halt && !i_wake && o_power_mode == `PM_RUN |-> ##2
	o_power_mode != `PM_RUN
) else $error("halt kept run mode");
chk_fast_osc_stop: assert property (
	(o_power_mode == `PM_SLEEP || o_power_mode == `PM_IDLE_SLOW_ONLY) [*2]
	|-> !o_fast_osc_enable
) else $error("fast oscillator ran in halt");
chk_slow_osc_stop: assert property (
	(o_power_mode == `PM_SLEEP || o_power_mode == `PM_IDLE_FAST_ONLY) [*2]
	|-> !o_slow_osc_enable && !o_crystal_enable
) else $error("slow oscillator ran in halt");
chk_cpu_clock_off: assert property (
	(o_power_mode != `PM_RUN) [*2] |-> !o_cpu_clk_en
) else $error("cpu clock on in halt");
chk_freq_code: assert property (
	o_fast_osc_freq_select != 2'h3
) else $error("freq code 3 applied");
chk_freq_hold: assert property (
	!i_fast_osc_ready [*6] |=> $stable(o_fast_osc_freq_select)
) else $error("freq changed while unstable");
chk_switch_min: assert property (
	$rose(o_switch_busy) |-> o_switch_busy [*4]
) else $error("switch shorter than four cycles");
chk_time_base_off: assert property (
	!i_crystal_ready [*6] |-> !o_time_base_clk_en
) else $error("time base on without crystal");
endmodule
bind system_clock_mode_control system_clock_mode_control_checker i_chk (.*);

// ===== verification/test_system_clock_mode_control.sv
// self-checking bench for the clock mode control block
// assumes the design and checker are compiled before it
`timescale 1ns/1ns
`include "clk_mode_regs.vh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
	failures++; $display("[ERR] %s expected %h seen %h", nm, ex, got); \
	end end
module test_system_clock_mode_control;
logic i_clk_sys = 0, i_rst = 1, i_avs_read = 0, i_avs_write = 0;
logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
logic [31:0] i_avs_writedata = 32'h0;
logic i_fast_osc_clk = 0, i_slow_osc_clk = 0, i_crystal_clk = 0;
logic i_fast_osc_ready = 0, i_crystal_ready = 0, i_slow_osc_ready = 1;
logic i_halt = 0, i_wake = 0;
wire [31:0] o_avs_readdata;
wire [1:0] o_fast_osc_freq_select;
wire [2:0] o_power_mode;
wire o_avs_waitrequest, o_fast_osc_enable, o_crystal_enable;
wire o_crystal_speedup, o_slow_osc_enable, o_time_base_clk_en;
wire o_cpu_clk_en, o_switch_busy, o_sys_clk;
int failures = 0, checked = 0, edges = 0;
logic [7:0] q;
system_clock_mode_control i_dut (.*);
////////////////////////////////////////////////////////////////////////////
// clocks: system 10 ns, fast 20 ns, slow 50 ns, crystal 30 ns
always #5 i_clk_sys = ~i_clk_sys;
always #10 i_fast_osc_clk = ~i_fast_osc_clk;
always #25 i_slow_osc_clk = ~i_slow_osc_clk;
always #15 i_crystal_clk = ~i_crystal_clk;
always @(posedge o_sys_clk) edges++;
////////////////////////////////////////////////////////////////////////////
// one bus cycle, held until waitrequest is seen low
task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
	@(posedge i_clk_sys);
	i_avs_address <= a;
	i_avs_writedata <= {24'h0, d};
	i_avs_read <= !wr;
	i_avs_write <= wr;
	do begin
		@(posedge i_clk_sys);
	end while (o_avs_waitrequest !== 1'b0);
	q = o_avs_readdata[7:0];
	i_avs_read <= 0;
	i_avs_write <= 0;
endtask
task wr(input logic [3:0] a, input logic [7:0] d);
	bus(1'b1, a, d);
	// register lands on the answer edge, its output pin one edge later
	repeat (2) @(posedge i_clk_sys);
endtask
task rd(input logic [3:0] a, input logic [7:0] ex, input string nm);
	bus(1'b0, a, 8'h00);
	`CHK(nm, ex, q)
endtask
// wait for a pending clock switch to finish
task settle();
	int n;
	repeat (2) @(posedge i_clk_sys);
	n = 0;
	while (o_switch_busy !== 1'b0 && n < 1000) begin
		@(posedge i_clk_sys);
		n++;
	end
	`CHK("switch busy", 1'b0, o_switch_busy)
	// glitch-free handoff needs up to two periods of the slowest clock
	repeat (250) @(posedge i_clk_sys);
endtask
// count system clock edges over 12800 ns
task rate(input int ex, input string nm);
	int a;
	a = edges;
	repeat (1280) @(posedge i_clk_sys);
	`CHK(nm, 1'b1, (edges - a <= ex + 1) && (edges - a + 1 >= ex))
endtask
////////////////////////////////////////////////////////////////////////////
// reset values and unused bits
task t_regs();
	rd(`ADDR_SYS_CLK_CTRL, `SCC_RESET, "scc reset");
	rd(`ADDR_FAST_OSC_CTRL, `FOC_RESET, "foc reset");
	rd(`ADDR_CRYSTAL_CTRL, `XOC_RESET, "xoc reset");
	rd(4'h2, 8'h00, "unmapped");
	wr(`ADDR_SYS_CLK_CTRL, 8'hfb);
	rd(`ADDR_SYS_CLK_CTRL, 8'he3, "scc unused");
	wr(`ADDR_SYS_CLK_CTRL, 8'he0);
	wr(`ADDR_FAST_OSC_CTRL, 8'hf0);
	rd(`ADDR_FAST_OSC_CTRL, 8'h00, "foc unused");
	wr(`ADDR_CRYSTAL_CTRL, 8'hf8);
	rd(`ADDR_CRYSTAL_CTRL, 8'h00, "xoc unused");
	settle();
	$display("t_regs done");
endtask
// fast oscillator enable, stable flag and frequency codes
task t_fast();
	int c;
	wr(`ADDR_FAST_OSC_CTRL, 8'h09);
	`CHK("fast en", 1'b1, o_fast_osc_enable)
	rd(`ADDR_FAST_OSC_CTRL, 8'h09, "fast unstable");
	`CHK("freq held", 2'h0, o_fast_osc_freq_select)
	i_fast_osc_ready <= 1;
	repeat (8) @(posedge i_clk_sys);
	rd(`ADDR_FAST_OSC_CTRL, 8'h0b, "fast stable");
	`CHK("freq applied", `FREQ_8MHZ, o_fast_osc_freq_select)
	for (c = 0; c < 4; c++) begin
		wr(`ADDR_FAST_OSC_CTRL, {4'h0, c[1:0], 2'b01});
		repeat (8) @(posedge i_clk_sys);
		`CHK("freq", (c == 3) ? 2'h0 : c[1:0], o_fast_osc_freq_select)
	end
	wr(`ADDR_FAST_OSC_CTRL, 8'h00);
	`CHK("fast off", 1'b0, o_fast_osc_enable)
	wr(`ADDR_FAST_OSC_CTRL, 8'h01);
	$display("t_fast done");
endtask
// crystal enable, speed-up and stable flag
task t_cryst();
	wr(`ADDR_CRYSTAL_CTRL, 8'h05);
	`CHK("xtal en", 1'b1, o_crystal_enable)
	`CHK("speedup", 1'b1, o_crystal_speedup)
	rd(`ADDR_CRYSTAL_CTRL, 8'h05, "xtal unstable");
	i_crystal_ready <= 1;
	repeat (8) @(posedge i_clk_sys);
	rd(`ADDR_CRYSTAL_CTRL, 8'h07, "xtal stable");
	`CHK("time base", 1'b1, o_time_base_clk_en)
	$display("t_cryst done");
endtask
// every select code, both sub sources, locked speed-up
task t_switch();
	int c;
	rd(`ADDR_FAST_OSC_CTRL, 8'h03, "fast ready");
	for (c = 0; c < 7; c++) begin
		wr(`ADDR_SYS_CLK_CTRL, {c[2:0], 5'h00});
		settle();
		rate(640 >> c, "divided rate");
	end
	i_crystal_ready <= 0;
	repeat (8) @(posedge i_clk_sys);
	wr(`ADDR_SYS_CLK_CTRL, 8'he4);
	repeat (20) @(posedge i_clk_sys);
	`CHK("wait stable", 1'b1, o_switch_busy)
	i_crystal_ready <= 1;
	settle();
	rate(426, "crystal rate");
	wr(`ADDR_CRYSTAL_CTRL, 8'h01);
	rd(`ADDR_CRYSTAL_CTRL, 8'h07, "speedup locked");
	`CHK("speedup pin", 1'b1, o_crystal_speedup)
	wr(`ADDR_SYS_CLK_CTRL, 8'he0);
	settle();
	rate(256, "slow rate");
	wr(`ADDR_CRYSTAL_CTRL, 8'h01);
	rd(`ADDR_CRYSTAL_CTRL, 8'h03, "low power");
	`CHK("speedup off", 1'b0, o_crystal_speedup)
	$display("t_switch done");
endtask
// halt with each keep-bit pair, then wake
task t_halt();
	int k;
	logic [2:0] pm;
	for (k = 0; k < 4; k++) begin
		pm = (k == 0) ? `PM_SLEEP : (k == 1) ? `PM_IDLE_SLOW_ONLY :
			(k == 2) ? `PM_IDLE_FAST_ONLY : `PM_IDLE_BOTH_OSC;
		wr(`ADDR_SYS_CLK_CTRL, {6'h00, k[1:0]});
		settle();
		@(posedge i_clk_sys) i_halt <= 1;
		@(posedge i_clk_sys) i_halt <= 0;
		repeat (3) @(posedge i_clk_sys);
		`CHK("halt mode", pm, o_power_mode)
		`CHK("cpu off", 1'b0, o_cpu_clk_en)
		`CHK("fast keep", k[1], o_fast_osc_enable)
		`CHK("slow keep", k[0], o_slow_osc_enable)
		@(posedge i_clk_sys) i_wake <= 1;
		@(posedge i_clk_sys) i_wake <= 0;
		repeat (3) @(posedge i_clk_sys);
		`CHK("run mode", `PM_RUN, o_power_mode)
		`CHK("cpu on", 1'b1, o_cpu_clk_en)
	end
	$display("t_halt done");
endtask
////////////////////////////////////////////////////////////////////////////
task give_verdict();
	$display("checked %0d failures %0d", checked, failures);
	if (failures == 0 && checked > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask
initial begin
	#400000;
	failures++;
	give_verdict();
end
initial begin
	repeat (3) @(posedge i_clk_sys);
	i_rst <= 0;
	t_regs();
	t_fast();
	t_cryst();
	t_switch();
	t_halt();
	give_verdict();
end
endmodule
